// ==== dv/hscd_host.sv ====
`default_nettype none
// Descriptor consumer standing where the upstream host would be.
module hscd_host (
  input wire logic clk_sys,
  input wire logic clr,
  input wire logic slow,
  input wire logic desc_valid,
  input wire logic [7:0] desc_data,
  input wire logic desc_last,
  output logic desc_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] got [32];
  int cnt = 0;
  logic done = 1'b0;
  logic tick = 1'b0;
  // A slow host stalls every other cycle to exercise the hold of each byte.
  assign desc_ready = !slow || tick;
  always @(posedge clk_sys) begin
    tick <= !tick;
    if (clr) begin
      cnt <= 0;
      done <= 1'b0;
    end else if (desc_valid && desc_ready) begin
      got[cnt] <= desc_data;
      cnt <= cnt + 1;
      if (desc_last) begin
        done <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ==== dv/hscd_top_test.sv ====
`default_nettype none
module hscd_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic up = 1'b0, lo = 1'b0, gang = 1'b0;
  logic [4:0] port_power_request = 5'h00;
  logic desc_req = 1'b0, desc_sel_config = 1'b0, clr = 1'b0, slow = 1'b0;
  logic desc_ready, desc_valid, desc_last, p1_sw, p5_sw, p5_data;
  logic [7:0] desc_data;
  logic [3:0] p_sw;
  logic [4:0] p_ovr;
  hscd_pkg::hscd_cfg_type cfg;
  int errors = 0;
  int compares = 0;
  logic [7:0] dev_exp [18] = '{8'h12, 8'h01, 8'h00, 8'h01, 8'h09, 8'h00, 8'h00, 8'h08, 8'h3C,
    8'h5A, 8'hC6, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h01};
  logic [7:0] cfg_exp [25] = '{8'h09, 8'h02, 8'h19, 8'h00, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00,
    8'h09, 8'h04, 8'h00, 8'h00, 8'h01, 8'h09, 8'h00, 8'h00, 8'h00,
    8'h07, 8'h05, 8'h81, 8'h03, 8'h01, 8'h00, 8'hFF};
  always #2.5 clk_sys = ~clk_sys;
  // Identifier values are arbitrary.
  hscd_top #(.VENDOR_ID(16'h5A3C), .PRODUCT_ID(16'h00C6)) i_dut (.clk_sys(clk_sys), .rst(rst),
    .port5_plus_or_upper_select_strap(up), .port5_minus_or_lower_select_strap(lo),
    .port5_overcurrent_or_gang_strap(gang), .port_power_request(port_power_request),
    .port1_overcurrent_in_n(1'b1), .port_overcurrent_n(4'hF), .desc_req(desc_req),
    .desc_sel_config(desc_sel_config), .desc_ready(desc_ready), .desc_valid(desc_valid),
    .desc_data(desc_data), .desc_last(desc_last), .port1_power_switch_out(p1_sw),
    .port_power_switch_out(p_sw), .port5_power_switch_out(p5_sw), .port_overcurrent(p_ovr),
    .port5_data_enable(p5_data), .config_status(cfg));
  hscd_host i_host (.clk_sys(clk_sys), .clr(clr), .slow(slow), .desc_valid(desc_valid),
    .desc_data(desc_data), .desc_last(desc_last), .desc_ready(desc_ready));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic fetch(input logic sel, input logic stall, input int n);
    clr = 1'b1;
    desc_req = 1'b1;
    desc_sel_config = sel;
    slow = stall;
    @(posedge clk_sys);
    #1 desc_req = 1'b0;
    clr = 1'b0;
    for (int i = 0; i < 200 && !i_host.done; i++) begin
      @(posedge clk_sys);
    end
    #1 chk(16'(i_host.cnt), 16'(n));
  endtask
  // One task, run once per strapping: boot, then check pins, status and both descriptors.
  task automatic run_mode(input logic u, input logic l, input logic g, input logic self_p,
                          input logic gng, input logic [2:0] ports);
    rst = 1'b1;
    {up, lo, gang} = {u, l, g};
    port_power_request = 5'h10;
    repeat (8) @(posedge clk_sys);
    #1 rst = 1'b0;
    repeat (10) @(posedge clk_sys);
    #1 {up, lo, gang} = ~{u, l, g};
    repeat (4) @(posedge clk_sys);
    #1 chk(16'(cfg.port_count), 16'(ports));
    chk(16'({cfg.self_powered, cfg.ganged}), 16'({self_p, gng}));
    chk(16'({p5_sw, p5_data, p1_sw}), 16'({self_p, self_p, 1'b0}));
    port_power_request = 5'h08;
    repeat (4) @(posedge clk_sys);
    #1 chk(16'(p1_sw), 16'(gng));
    chk(16'(p_sw), gng ? 16'h0000 : 16'h0008);
    chk(16'(p_ovr), 16'h0000);
    fetch(1'b0, 1'b0, 18);
    for (int i = 0; i < 18; i++) begin
      chk(16'(i_host.got[i]), 16'(dev_exp[i]));
    end
    cfg_exp[7] = self_p ? 8'h60 : 8'hA0;
    cfg_exp[8] = self_p ? 8'h01 : 8'hFA;
    @(posedge clk_sys);
    #1 fetch(1'b1, 1'b1, 25);
    for (int i = 0; i < 25; i++) begin
      chk(16'(i_host.got[i]), 16'(cfg_exp[i]));
    end
  endtask
  initial begin
    run_mode(1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 3'h5);
    run_mode(1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 3'h4);
    run_mode(1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 3'h4);
    conclude();
  end
  // Three boots with two fetches each need well under a thousand cycles.
  initial begin
    repeat (5000) @(posedge clk_sys);
    errors++;
    conclude();
  end
endmodule
`default_nettype wire

// ==== hdl/hscd_pkg.sv ====
// Function
// - Configuration is sampled from straps just after power-on reset releases and held afterwards.
// - Both select straps low: self-powered, five individual ports, straps become port 5 pins.
// - Upper low, lower and gang high: bus-powered, four individual ports, port 5 unused.
// - Upper and gang low, lower high: bus-powered, four ganged ports, port 5 switch ignored.
// - Ganged mode drives all ports from the port 1 switch and overcurrent.
// - Device descriptor is 18 bytes, length 12h, type 01h.
// - Release 0100h at offset 2, then class 09h, subclass and protocol 00h.
// - Control endpoint packet size 8 at offset 7.
// - Vendor and product identifiers at offsets 8 and 10, release 0100h at 12.
// - Manufacturer, product and serial string indices are zero.
// - One configuration reported at offset 17.
// - Configuration descriptor is 9 bytes, type 02h, total length 0019h.
// - One interface and configuration value 1.
// - Configuration string index is zero.
// - Self-powered reports attributes 60h and power 01h.
// - Bus-powered reports attributes A0h and power FAh.
// - Interface descriptor 9 bytes, type 04h, number 0, alternate 0, one endpoint.
// - Interface class 09h, subclass, protocol and string index 00h.
// - Endpoint descriptor 7 bytes, type 05h.
// - Endpoint address 81h, attributes 03h for interrupt.
// - Endpoint packet size 0001h and interval FFh.
`default_nettype none
package hscd_pkg;
  typedef enum logic [2:0] {
    HSCD_SELF_INDIV = 3'h1,
    HSCD_BUS_INDIV = 3'h2,
    HSCD_BUS_GANG = 3'h4
  } hscd_mode_type;
  typedef struct packed {
    hscd_mode_type mode;
    logic self_powered;
    logic ganged;
    logic [2:0] port_count;
    logic strap_error;
  } hscd_cfg_type;
  localparam logic [4:0] HSCD_DEV_LEN = 5'h12;
  localparam logic [4:0] HSCD_CFG_TOTAL = 5'h19;
  localparam logic [2:0] HSCD_PORTS_SELF = 3'h5;
  localparam logic [2:0] HSCD_PORTS_BUS = 3'h4;
  localparam logic [7:0] HSCD_ATTR_SELF = 8'h60;
  localparam logic [7:0] HSCD_ATTR_BUS = 8'hA0;
  localparam logic [7:0] HSCD_POWER_SELF = 8'h01;
  localparam logic [7:0] HSCD_POWER_BUS = 8'hFA;
  localparam int HSCD_CFG_ATTR_OFS = 7;
  localparam int HSCD_CFG_POWER_OFS = 8;
  localparam int HSCD_VID_OFS = 8;
  localparam int HSCD_PID_OFS = 10;
  localparam logic [1:0] HSCD_SETTLE_EDGES = 2'h3;
endpackage
`default_nettype wire

// ==== hdl/hscd_rom.sv ====
`default_nettype none
// Fixed descriptor image with registered read data; mode bytes patched in.
module hscd_rom #(
  parameter logic [15:0] VENDOR_ID = 16'hABCD,
  parameter logic [15:0] PRODUCT_ID = 16'h0042
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic sel_config,
  input wire logic [4:0] addr,
  input wire logic self_powered,
  output logic [7:0] data
);
  logic [7:0] dev_byte;
  logic [7:0] cfg_byte;

  always_comb begin
    unique case (addr)
      5'h00: dev_byte = 8'h12;
      5'h01: dev_byte = 8'h01;
      5'h02: dev_byte = 8'h00;
      5'h03: dev_byte = 8'h01;
      5'h04: dev_byte = 8'h09;
      5'h07: dev_byte = 8'h08;
      5'h08: dev_byte = VENDOR_ID[7:0];
      5'h09: dev_byte = VENDOR_ID[15:8];
      5'h0A: dev_byte = PRODUCT_ID[7:0];
      5'h0B: dev_byte = PRODUCT_ID[15:8];
      5'h0C: dev_byte = 8'h00;
      5'h0D: dev_byte = 8'h01;
      5'h11: dev_byte = 8'h01;
      default: dev_byte = 8'h00;
    endcase
  end

  always_comb begin
    unique case (addr)
      5'h00: cfg_byte = 8'h09;
      5'h01: cfg_byte = 8'h02;
      5'h02: cfg_byte = 8'h19;
      5'h04: cfg_byte = 8'h01;
      5'h05: cfg_byte = 8'h01;
      5'h07: cfg_byte = self_powered ? hscd_pkg::HSCD_ATTR_SELF : hscd_pkg::HSCD_ATTR_BUS;
      5'h08: cfg_byte = self_powered ? hscd_pkg::HSCD_POWER_SELF : hscd_pkg::HSCD_POWER_BUS;
      5'h09: cfg_byte = 8'h09;
      5'h0A: cfg_byte = 8'h04;
      5'h0D: cfg_byte = 8'h01;
      5'h0E: cfg_byte = 8'h09;
      5'h12: cfg_byte = 8'h07;
      5'h13: cfg_byte = 8'h05;
      5'h14: cfg_byte = 8'h81;
      5'h15: cfg_byte = 8'h03;
      5'h16: cfg_byte = 8'h01;
      5'h18: cfg_byte = 8'hFF;
      default: cfg_byte = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      data <= 8'h00;
    end else begin
      data <= sel_config ? cfg_byte : dev_byte;
    end
  end
endmodule
`default_nettype wire

// ==== hdl/hscd_top.sv ====
`default_nettype none
// Strap capture, pin reassignment and descriptor byte streamer.
module hscd_top #(
  parameter logic [15:0] VENDOR_ID = 16'hABCD, // Arbitrary value.
  parameter logic [15:0] PRODUCT_ID = 16'h0042 // Arbitrary value.
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic port5_plus_or_upper_select_strap,
  input wire logic port5_minus_or_lower_select_strap,
  input wire logic port5_overcurrent_or_gang_strap,
  input wire logic [4:0] port_power_request,
  input wire logic port1_overcurrent_in_n,
  input wire logic [3:0] port_overcurrent_n,
  input wire logic desc_req,
  input wire logic desc_sel_config,
  input wire logic desc_ready,
  output logic desc_valid,
  output logic [7:0] desc_data,
  output logic desc_last,
  output logic port1_power_switch_out,
  output logic [3:0] port_power_switch_out,
  output logic port5_power_switch_out,
  output logic [4:0] port_overcurrent,
  output logic port5_data_enable,
  output hscd_pkg::hscd_cfg_type config_status
);
  logic [2:0] s_up;
  logic [2:0] s_lo;
  logic [2:0] s_gang;
  logic rst_seen;
  logic [1:0] settle;
  logic [4:0] rom_addr;
  logic cfg_locked;
  logic [4:0] addr;
  logic [4:0] last_addr;
  logic busy;
  logic sel_cfg;
  logic rom_valid;
  logic rom_last;
  logic [7:0] rom_data;
  hscd_pkg::hscd_cfg_type next_cfg;

  // Straps are pins: three-stage sampling, accepted when the last two agree.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s_up <= 3'h0;
      s_lo <= 3'h0;
      s_gang <= 3'h0;
    end else begin
      s_up <= {s_up[1:0], port5_plus_or_upper_select_strap};
      s_lo <= {s_lo[1:0], port5_minus_or_lower_select_strap};
      s_gang <= {s_gang[1:0], port5_overcurrent_or_gang_strap};
    end
  end

  always_comb begin
    next_cfg = '0;
    if (!s_up[2] && !s_lo[2]) begin
      next_cfg.mode = hscd_pkg::HSCD_SELF_INDIV;
      next_cfg.self_powered = 1'b1;
      next_cfg.port_count = hscd_pkg::HSCD_PORTS_SELF;
    end else if (!s_up[2] && s_gang[2]) begin
      next_cfg.mode = hscd_pkg::HSCD_BUS_INDIV;
      next_cfg.port_count = hscd_pkg::HSCD_PORTS_BUS;
    end else begin
      // Unlisted combinations fall back to the safest bus-powered ganged mode.
      next_cfg.mode = hscd_pkg::HSCD_BUS_GANG;
      next_cfg.ganged = 1'b1;
      next_cfg.port_count = hscd_pkg::HSCD_PORTS_BUS;
      next_cfg.strap_error = s_up[2];
    end
  end

  // Asynchronous reset cannot load a pin, so the straps are taken on the
  // first settled clock after release and then frozen.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rst_seen <= 1'b0;
      settle <= 2'h0;
      cfg_locked <= 1'b0;
      config_status <= '{mode: hscd_pkg::HSCD_BUS_GANG, self_powered: 1'b0, ganged: 1'b1,
                         port_count: hscd_pkg::HSCD_PORTS_BUS, strap_error: 1'b0};
    end else begin
      rst_seen <= 1'b1;
      // The sampling stages still hold their reset zeros for a few edges; waiting keeps
      // those zeros from being taken as a self-powered strapping.
      if (settle != hscd_pkg::HSCD_SETTLE_EDGES) begin
        settle <= settle + 2'h1;
      end
      if (rst_seen && (settle == hscd_pkg::HSCD_SETTLE_EDGES) && !cfg_locked && (s_up[2] == s_up[1]) &&
          (s_lo[2] == s_lo[1]) && (s_gang[2] == s_gang[1])) begin
        config_status <= next_cfg;
        cfg_locked <= 1'b1;
      end
    end
  end

  // Power pins follow the latched mode.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      port1_power_switch_out <= 1'b0;
      port_power_switch_out <= 4'h0;
      port5_power_switch_out <= 1'b0;
      port_overcurrent <= 5'h00;
      port5_data_enable <= 1'b0;
    end else if (config_status.ganged) begin
      port1_power_switch_out <= |port_power_request[3:0];
      port_power_switch_out <= 4'h0;
      port5_power_switch_out <= 1'b0;
      port_overcurrent <= {1'b0, {4{~port1_overcurrent_in_n}}};
      port5_data_enable <= 1'b0;
    end else begin
      port1_power_switch_out <= port_power_request[0];
      port_power_switch_out <= {port_power_request[3:1], 1'b0};
      port5_power_switch_out <= config_status.self_powered & port_power_request[4];
      port_overcurrent <= {config_status.self_powered & ~s_gang[2], ~port_overcurrent_n[3:1],
                           ~port1_overcurrent_in_n};
      port5_data_enable <= config_status.self_powered;
    end
  end

  assign last_addr = sel_cfg ? hscd_pkg::HSCD_CFG_TOTAL - 5'h01 : hscd_pkg::HSCD_DEV_LEN - 5'h01;

  // The ROM register reloads every edge, so a stalled byte is re-read from the address behind.
  assign rom_addr = (rom_valid && !desc_ready) ? addr - 5'h01 : addr;

  // Streamer: one byte per accepted beat; the ROM output register gives a one-cycle lead.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      busy <= 1'b0;
      addr <= 5'h00;
      sel_cfg <= 1'b0;
      rom_valid <= 1'b0;
      rom_last <= 1'b0;
    end else if (!busy) begin
      rom_valid <= 1'b0;
      if (desc_req && cfg_locked) begin
        busy <= 1'b1;
        sel_cfg <= desc_sel_config;
        addr <= 5'h00;
        rom_last <= 1'b0;
      end
    end else if (!rom_valid || desc_ready) begin
      if (rom_valid && rom_last) begin
        busy <= 1'b0;
        rom_valid <= 1'b0;
      end else begin
        rom_valid <= 1'b1;
        rom_last <= (addr == last_addr);
        addr <= addr + 5'h01;
      end
    end
  end

  hscd_rom #(
    .VENDOR_ID(VENDOR_ID),
    .PRODUCT_ID(PRODUCT_ID)
  ) u_rom (
    .clk_sys(clk_sys),
    .rst(rst),
    .sel_config(sel_cfg),
    .addr(rom_addr),
    .self_powered(config_status.self_powered),
    .data(rom_data)
  );

  assign desc_valid = rom_valid;
  assign desc_data = rom_data;
  assign desc_last = rom_valid & rom_last;

  AST_LOCK_STABLE: assert property (@(posedge clk_sys) disable iff (rst)
    cfg_locked |=> $stable(config_status)) else $error("config changed after lock");
  AST_SELF_PORTS: assert property (@(posedge clk_sys) disable iff (rst)
    config_status.self_powered |-> config_status.port_count == 3'h5) else $error("self mode port count");
  AST_GANG_P5: assert property (@(posedge clk_sys) disable iff (rst)
    config_status.ganged |=> !port5_power_switch_out) else $error("port 5 switch in ganged");
  AST_GANG_OVR: assert property (@(posedge clk_sys) disable iff (rst)
    config_status.ganged && $stable(config_status) |=> port_overcurrent[3:0] == {4{~$past(port1_overcurrent_in_n)}})
    else $error("ganged overcurrent");
  AST_FIRST_BYTE: assert property (@(posedge clk_sys) disable iff (rst)
    desc_valid && !$past(desc_valid) && !sel_cfg |-> desc_data == 8'h12) else $error("device length byte");
  AST_CFG_FIRST: assert property (@(posedge clk_sys) disable iff (rst)
    desc_valid && !$past(desc_valid) && sel_cfg |-> desc_data == 8'h09) else $error("config length byte");
  AST_ATTR: assert property (@(posedge clk_sys) disable iff (rst)
    desc_valid && sel_cfg && addr == 5'h08 |-> desc_data == (config_status.self_powered ? 8'h60 : 8'hA0))
    else $error("attributes byte");
  AST_LAST_HOLD: assert property (@(posedge clk_sys) disable iff (rst)
    desc_valid && !desc_ready |=> desc_valid && $stable(desc_data)) else $error("byte dropped under stall");
endmodule
`default_nettype wire
